// ===== rtl/occal_pkg.sv
/*
 * occal_pkg: shared constants, register map and carrier types for the
 * oscillator power and resonator calibration block.
 * Assumes a 250 MHz pclk; the low-frequency clock arrives as a synchronous level.
 */
package occal_pkg;
    // clock rate
    localparam int unsigned CLK_HZ         = 250_000_000;
    // settling delays, nanoseconds as printed
    localparam longint unsigned SETTLE2_NS = 480_000;
    localparam longint unsigned SETTLE3_NS = 1_460_000;
    localparam longint unsigned SETTLE4_NS = 2_440_000;
    localparam longint unsigned SETTLE5_NS = 5_140_000;
    localparam longint unsigned CLK_PER_NS = 4;
    // least waits round up to whole cycles
    localparam int unsigned SETTLE2_CYC = int'((SETTLE2_NS + CLK_PER_NS - 1) / CLK_PER_NS);
    localparam int unsigned SETTLE3_CYC = int'((SETTLE3_NS + CLK_PER_NS - 1) / CLK_PER_NS);
    localparam int unsigned SETTLE4_CYC = int'((SETTLE4_NS + CLK_PER_NS - 1) / CLK_PER_NS);
    localparam int unsigned SETTLE5_CYC = int'((SETTLE5_NS + CLK_PER_NS - 1) / CLK_PER_NS);

    // register byte offsets
    localparam logic [7:0] CFG_OFS     = 8'h00;
    localparam logic [7:0] CMD_OFS     = 8'h04;
    localparam logic [7:0] STATUS_OFS  = 8'h08;
    localparam logic [7:0] RESULT_OFS  = 8'h0C;
    localparam logic [7:0] IRQ_STS_OFS = 8'h10;
    localparam logic [7:0] IRQ_EN_OFS  = 8'h14;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h18;

    // config register fields
    localparam int STARTUP_LSB = 0;   // hs_osc_startup_ctrl [2:0]
    localparam int CALPER_LSB  = 4;   // cal_period_count [1:0]
    localparam int HSDIV_LSB   = 8;   // hs_clock_divider [1:0]
    localparam int TO1_LSB     = 12;  // test_out1_select [2:0]
    localparam int TO2_LSB     = 16;  // test_out2_select [2:0]
    localparam int MODE2_BIT   = 20;  // measurement mode 2
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
    localparam logic [2:0]  TEST_OUT_LF = 3'h7;

    // opcodes written to the command register
    localparam logic [3:0] OP_TOF       = 4'h1;
    localparam logic [3:0] OP_TOF_RPT   = 4'h2;
    localparam logic [3:0] OP_TEMP      = 4'h3;
    localparam logic [3:0] OP_TEMP_RPT  = 4'h4;
    localparam logic [3:0] OP_CAL       = 4'h5;

    // interrupt bits
    localparam int IRQ_CAL_DONE = 0;
    localparam int IRQ_MEAS_GO  = 1;
    localparam int IRQ_W        = 2;

    // decoded configuration
    typedef struct packed {
        logic       mode2;
        logic [2:0] to2_sel;
        logic [2:0] to1_sel;
        logic [1:0] hs_div;
        logic [1:0] cal_per;
        logic [2:0] startup;
    } occal_cfg_t;

    // measurement handshake with the tdc core
    typedef struct packed {
        logic req;
        logic done;
    } occal_meas_t;
endpackage

// ===== rtl/occal_lfclk.sv
/*
 * occal_lfclk: free-running 32.768 kHz reference, edge pulses and a
 * divide-by-eight output. Assumes the lf input is already synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module occal_lfclk (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic lf_in,
    output logic      lf_level,
    output logic      lf_rise,
    output logic      lf_div8
);
    logic       prev_reg;
    logic [2:0] div_reg;

    // previous sample for edge detect; nothing can stop this path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= lf_in;
        end
    end

    // divide by eight counts rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 3'h0;
        end else if (lf_in && !prev_reg) begin
            div_reg <= div_reg + 3'h1;
        end
    end

    assign lf_level = prev_reg;
    assign lf_rise  = lf_in && !prev_reg;
    assign lf_div8  = div_reg[2];
endmodule
`default_nettype wire

// ===== rtl/occal_calcnt.sv
/*
 * occal_calcnt: counts divided high-speed clock periods across 2..16
 * low-frequency periods; result in 16.16 fixed point.
 * Assumes hs_tick pulses once per high-speed period while the oscillator runs.
 */
`timescale 1ns/1ps
`default_nettype none
module occal_calcnt (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic        lf_rise,
    input  wire logic        hs_tick,
    input  wire logic [1:0]  cal_per,
    input  wire logic [1:0]  hs_div,
    output logic             busy,
    output logic             done,
    output logic [31:0]      result
);
    logic        run_reg;
    logic        armed_reg;
    logic [4:0]  per_reg;
    logic [15:0] cnt_reg;
    logic [1:0]  pre_reg;
    logic        done_reg;
    logic [31:0] res_reg;
    logic [4:0]  target;
    logic [1:0]  div_max;

    assign target  = 5'(5'd2 << cal_per);
    assign div_max = (hs_div == 2'd0) ? 2'd0 : (hs_div == 2'd1) ? 2'd1 : 2'd3;

    // start pulse at first lf edge, stop after the chosen period count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_reg <= 1'b0;
            run_reg   <= 1'b0;
            per_reg   <= 5'd0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start && !armed_reg && !run_reg) begin
                armed_reg <= 1'b1;
            end else if (armed_reg && lf_rise) begin
                armed_reg <= 1'b0;
                run_reg   <= 1'b1;
                per_reg   <= 5'd0;
            end else if (run_reg && lf_rise) begin
                per_reg <= per_reg + 5'd1;
                if (per_reg + 5'd1 == target) begin
                    run_reg  <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end

    // divided hs period count, integer part only; fraction stays zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
            pre_reg <= 2'd0;
        end else if (armed_reg) begin
            cnt_reg <= 16'h0000;
            pre_reg <= 2'd0;
        end else if (run_reg && hs_tick) begin
            if (pre_reg == div_max) begin
                pre_reg <= 2'd0;
                cnt_reg <= cnt_reg + 16'h0001;
            end else begin
                pre_reg <= pre_reg + 2'd1;
            end
        end
    end

    // capture result when the interval closes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_reg <= 32'h0000_0000;
        end else if (run_reg && lf_rise && (per_reg + 5'd1 == target)) begin
            res_reg <= {cnt_reg, 16'h0000};
        end
    end

    assign busy   = armed_reg || run_reg;
    assign done   = done_reg;
    assign result = res_reg;
endmodule
`default_nettype wire

// ===== rtl/occal_top.sv
/*
 * occal_top: oscillator power control, settling delay, low-frequency
 * clock outputs and resonator calibration behind an APB slave.
 * Assumes one 250 MHz clock, synchronous pins, a tdc core answering
 * meas_done after each meas_start, and hs_tick from the oscillator path.
 */
// Contract
// R1 - startup setting 0 keeps oscillator off, 1 runs it continuously; at 0 the code still switches it on during calibration
// R2 - above 1, measurement opcodes switch the oscillator on for that measurement
// R3 - wait 480 us, 1.46 ms, 2.44 ms or 5.14 ms before measuring
// R4 - low-frequency reference controls start-up and calibration; the code counts the start-up wait in pclk cycles
// R5 - low-frequency oscillator runs always, no setting disables it
// R6 - test_out1_select 7 drives low-power clock onto fire input pin
// R7 - test_out2_select 7 drives low-power clock divided by eight onto start enable
// R8 - high-speed clock serves calibration, eeprom, operations and mode 2 measuring
// R9 - controller sets cal_period_count and issues calibrate opcode; device runs it
// R10 - calibration start and stop pulses come from low-frequency clock edges
// R11 - on completion store result and raise interrupt flag
// R12 - interval spans 2, 4, 8 or 16 low-frequency periods
// R13 - result counts high-speed periods after divide by 1, 2 or 4
// R14 - result is 32-bit unsigned, 16 integer and 16 fraction bits
// R15 - controller keeps start input enabled during calibration
// R16 - above 1, oscillator switches off when triggered measurement finishes
`timescale 1ns/1ps
`default_nettype none
module occal_top #(
    parameter int unsigned SETTLE2_CYC = occal_pkg::SETTLE2_CYC,
    parameter int unsigned SETTLE3_CYC = occal_pkg::SETTLE3_CYC,
    parameter int unsigned SETTLE4_CYC = occal_pkg::SETTLE4_CYC,
    parameter int unsigned SETTLE5_CYC = occal_pkg::SETTLE5_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        lf_osc_input_pin,
    input  wire logic        hs_tick,
    output logic             hs_osc_enable,
    output logic             hs_clk_enable,
    output logic             mode2_hs_enable,
    output logic             meas_start,
    input  wire logic        meas_done,
    input  wire logic        start_input_enabled,
    output logic             fire_input_pin_o,
    output logic             fire_input_pin_oe,
    output logic             start_enable_pin_o,
    output logic             start_enable_pin_oe,
    output logic             irq
);
    typedef enum logic [3:0] {
        OCAL_IDLE   = 4'b0001,
        OCAL_SETTLE = 4'b0010,
        OCAL_MEAS   = 4'b0100,
        OCAL_CAL    = 4'b1000
    } occal_state_t;

    occal_state_t                  state_reg;
    occal_state_t                  state_next;
    occal_pkg::occal_cfg_t         cfg;
    logic [31:0]                   cfg_reg;
    logic [31:0]                   wait_reg;
    logic [occal_pkg::IRQ_W-1:0]   sts_reg;
    logic [occal_pkg::IRQ_W-1:0]   en_reg;
    logic [31:0]                   prdata_reg;
    logic                          cal_err_reg;
    logic                          wr_acc;
    logic                          rd_acc;
    logic                          cmd_wr;
    logic [3:0]                    opcode;
    logic                          meas_op;
    logic                          cal_op;
    logic                          cal_start;
    logic                          cal_busy;
    logic                          cal_done;
    logic [31:0]                   cal_result;
    logic                          lf_level;
    logic                          lf_rise;
    logic                          lf_div8;
    logic                          addr_ok;

    // settling count for a startup setting
    function automatic logic [31:0] settle_cycles(input logic [2:0] sel);
        case (sel)
            3'd2:    settle_cycles = 32'(SETTLE2_CYC);
            3'd3:    settle_cycles = 32'(SETTLE3_CYC);
            3'd4:    settle_cycles = 32'(SETTLE4_CYC);
            default: settle_cycles = 32'(SETTLE5_CYC);
        endcase
    endfunction

    assign cfg = occal_pkg::occal_cfg_t'({
        cfg_reg[occal_pkg::MODE2_BIT],
        cfg_reg[occal_pkg::TO2_LSB +: 3],
        cfg_reg[occal_pkg::TO1_LSB +: 3],
        cfg_reg[occal_pkg::HSDIV_LSB +: 2],
        cfg_reg[occal_pkg::CALPER_LSB +: 2],
        cfg_reg[occal_pkg::STARTUP_LSB +: 3]});

    // apb access phase; zero wait states
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign addr_ok = (paddr == occal_pkg::CFG_OFS) || (paddr == occal_pkg::CMD_OFS)
                   || (paddr == occal_pkg::STATUS_OFS) || (paddr == occal_pkg::RESULT_OFS)
                   || (paddr == occal_pkg::IRQ_STS_OFS) || (paddr == occal_pkg::IRQ_EN_OFS)
                   || (paddr == occal_pkg::IRQ_CLR_OFS);
    assign pslverr = psel && penable && !addr_ok;
    assign cmd_wr  = wr_acc && (paddr == occal_pkg::CMD_OFS);
    assign opcode  = pwdata[3:0];
    assign meas_op = cmd_wr && ((opcode == occal_pkg::OP_TOF) || (opcode == occal_pkg::OP_TOF_RPT)
                   || (opcode == occal_pkg::OP_TEMP) || (opcode == occal_pkg::OP_TEMP_RPT));
    // calibration needs the start input held enabled by the controller
    assign cal_op  = cmd_wr && (opcode == occal_pkg::OP_CAL);   // [R9]

    // configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= occal_pkg::CFG_RESET;
        end else if (wr_acc && paddr == occal_pkg::CFG_OFS) begin
            cfg_reg <= pwdata & 32'h0017_7337;
        end
    end

    // sequencer: commands are ignored while one is in flight
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OCAL_IDLE: begin
                if (meas_op) begin
                    // startup above 1 starts oscillator and waits; else go now
                    state_next = (cfg.startup > 3'd1) ? OCAL_SETTLE : OCAL_MEAS; // [R2]
                end else if (cal_op) begin
                    state_next = OCAL_CAL;                                 // [R9]
                end
            end
            OCAL_SETTLE: begin
                if (wait_reg == 32'h0000_0000) begin
                    state_next = OCAL_MEAS;                                // [R3]
                end
            end
            OCAL_MEAS: begin
                if (meas_done) begin
                    state_next = OCAL_IDLE;                                // [R16]
                end
            end
            OCAL_CAL: begin
                if (cal_done) begin
                    state_next = OCAL_IDLE;
                end
            end
            default: state_next = OCAL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= OCAL_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // settle counter: loaded on the opcode, counts down on pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_reg <= 32'h0000_0000;
        end else if (state_reg == OCAL_IDLE && meas_op) begin
            wait_reg <= settle_cycles(cfg.startup) - 32'h0000_0001;   // [R3]
        end else if (state_reg == OCAL_SETTLE && wait_reg != 32'h0000_0000) begin
            wait_reg <= wait_reg - 32'h0000_0001;
        end
    end

    // one-cycle start to the tdc core on entering measurement
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_start <= 1'b0;
        end else begin
            meas_start <= (state_reg != OCAL_MEAS) && (state_next == OCAL_MEAS);
        end
    end

    // oscillator power: off at 0 except during calibration, on at 1, else only while a command runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_osc_enable <= 1'b0;
        end else if (cfg.startup == 3'd0) begin
            hs_osc_enable <= (state_next == OCAL_CAL);                // [R1]
        end else if (cfg.startup == 3'd1) begin
            hs_osc_enable <= 1'b1;                                    // [R1]
        end else begin
            hs_osc_enable <= (state_next != OCAL_IDLE);               // [R2] [R16]
        end
    end

    // clock gates for operations and the mode 2 measuring path
    assign hs_clk_enable   = hs_osc_enable;                           // [R8]
    assign mode2_hs_enable = hs_osc_enable && cfg.mode2;              // [R8]

    // low-frequency reference, never gated by any setting
    occal_lfclk u_lf (
        .pclk     (pclk),
        .presetn  (presetn),
        .lf_in    (lf_osc_input_pin),
        .lf_level (lf_level),
        .lf_rise  (lf_rise),
        .lf_div8  (lf_div8)
    );                                                                // [R4] [R5]

    // test outputs; registered so the pins never glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fire_input_pin_o    <= 1'b0;
            fire_input_pin_oe   <= 1'b0;
            start_enable_pin_o  <= 1'b0;
            start_enable_pin_oe <= 1'b0;
        end else begin
            fire_input_pin_oe   <= (cfg.to1_sel == occal_pkg::TEST_OUT_LF);          // [R6]
            fire_input_pin_o    <= (cfg.to1_sel == occal_pkg::TEST_OUT_LF) && lf_level;
            start_enable_pin_oe <= (cfg.to2_sel == occal_pkg::TEST_OUT_LF);          // [R7]
            start_enable_pin_o  <= (cfg.to2_sel == occal_pkg::TEST_OUT_LF) && lf_div8;
        end
    end

    assign cal_start = (state_reg == OCAL_CAL) && !cal_done;

    // calibration interval counter
    occal_calcnt u_cal (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (cal_start),
        .lf_rise (lf_rise),                                           // [R10]
        .hs_tick (hs_tick && hs_osc_enable),
        .cal_per (cfg.cal_per),                                       // [R12]
        .hs_div  (cfg.hs_div),                                        // [R13]
        .busy    (cal_busy),
        .done    (cal_done),
        .result  (cal_result)                                         // [R11] [R14]
    );

    // sticky flag if the start input dropped during calibration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_err_reg <= 1'b0;
        end else if (cal_op) begin
            cal_err_reg <= 1'b0;
        end else if (cal_busy && !start_input_enabled) begin
            cal_err_reg <= 1'b1;                                      // [R15]
        end
    end

    // interrupt status: set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_reg <= '0;
        end else begin
            sts_reg <= (sts_reg & ~((wr_acc && paddr == occal_pkg::IRQ_CLR_OFS)
                                    ? pwdata[occal_pkg::IRQ_W-1:0] : '0))
                     | {meas_start, cal_done};                        // [R11]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= '0;
        end else if (wr_acc && paddr == occal_pkg::IRQ_EN_OFS) begin
            en_reg <= pwdata[occal_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(sts_reg & en_reg);

    // read mux registered in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                occal_pkg::CFG_OFS:     prdata_reg <= cfg_reg;
                occal_pkg::STATUS_OFS:  prdata_reg <= {25'h0, cal_err_reg, cal_busy,
                                                       hs_osc_enable, state_reg};
                occal_pkg::RESULT_OFS:  prdata_reg <= cal_result;
                occal_pkg::IRQ_STS_OFS: prdata_reg <= {30'h0, sts_reg};
                occal_pkg::IRQ_EN_OFS:  prdata_reg <= {30'h0, en_reg};
                default:                prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = rd_acc ? prdata_reg : 32'h0000_0000;
endmodule
`default_nettype wire

// ===== dv/occal_props.sv
/* occal_props: port-level assertions for occal_top.
   assumes one pclk domain, reset low on presetn, bound by port name. */
`timescale 1ns/1ps
`default_nettype none
module occal_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        lf_osc_input_pin,
    input wire logic        hs_osc_enable,
    input wire logic        hs_clk_enable,
    input wire logic        mode2_hs_enable,
    input wire logic        meas_start,
    input wire logic        fire_input_pin_o,
    input wire logic        fire_input_pin_oe,
    input wire logic        start_enable_pin_oe,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed write; config-driven outputs move only after one
    logic wr;
    assign wr = psel & penable & pwrite;

    AST_PREADY: assert property (psel && penable |-> pready) else $error("pready low");
    AST_SLVERR: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    AST_PRDATA: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0000_0000)
        else $error("prdata outside read");
    AST_HSCLK: assert property (hs_clk_enable == hs_osc_enable)
        else $error("hs clock gate off oscillator");
    AST_MODE2: assert property (mode2_hs_enable |-> hs_osc_enable)
        else $error("mode2 clock without oscillator");
    AST_MEAS_PULSE: assert property (meas_start |=> !meas_start)
        else $error("start pulse too long");
    AST_FIRE_LF: assert property (fire_input_pin_oe && $past(fire_input_pin_oe, 3)
        |-> fire_input_pin_o == $past(lf_osc_input_pin, 2)) else $error("fire pin not lf");
    AST_OE_CAUSE: assert property ($changed(fire_input_pin_oe)
        || $changed(start_enable_pin_oe) |-> $past(wr) || $past(wr, 2))
        else $error("pin enable moved without write");
    AST_OSC_RISE: assert property ($rose(hs_osc_enable) |-> $past(wr) || $past(wr, 2))
        else $error("oscillator on without request");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
        else $error("irq dropped without write");
endmodule
bind occal_top occal_props u_occal_props (.*);
`default_nettype wire

// ===== dv/occal_partner.sv
/* occal_partner: lf oscillator, hs oscillator ticks and tdc core.
   assumes one pclk; lf period scaled to 2*LF_HALF cycles. */
`timescale 1ns/1ps
`default_nettype none
module occal_partner #(
    parameter int LF_HALF = 40,
    parameter int HS_PER  = 4
) (
    input  wire logic       pclk,
    input  wire logic [7:0] lat,
    input  wire logic       hs_osc_enable,
    input  wire logic       meas_start,
    output logic            lf_osc_input_pin,
    output logic            hs_tick,
    output logic            meas_done
);
    int cnt  = 0;
    int left = 0;
    initial begin
        lf_osc_input_pin = 1'b0;
        hs_tick = 1'b0;
        meas_done = 1'b0;
    end
    // lf never stops; ticks off-phase so none meets an lf edge
    always @(posedge pclk) begin
        cnt <= (cnt + 1) % (2 * LF_HALF);
        if (cnt % LF_HALF == LF_HALF - 1) lf_osc_input_pin <= ~lf_osc_input_pin;
        hs_tick <= hs_osc_enable && (cnt % HS_PER == 2);
    end
    // core answers lat cycles after each start
    always @(posedge pclk) begin
        if (meas_start) left <= int'(lat);
        else if (left > 0) left <= left - 1;
        meas_done <= (left == 1);
    end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
/* testbench: apb regression of occal_top against the partner model.
   assumes settle counts 20/40/60/80 and an 80-cycle lf period. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        start_input_enabled = 1'b1;
    logic [7:0]  lat = 8'h02;
    logic [31:0] prdata, q;
    logic        pready, pslverr, e, lf_osc_input_pin, hs_tick, meas_done, irq;
    logic        hs_osc_enable, hs_clk_enable, mode2_hs_enable, meas_start;
    logic        fire_input_pin_o, fire_input_pin_oe, start_enable_pin_o, start_enable_pin_oe;
    logic        f0, s0;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n, x;

    occal_top #(.SETTLE2_CYC(20), .SETTLE3_CYC(40), .SETTLE4_CYC(60), .SETTLE5_CYC(80))
        u_occal_top (.*);
    occal_partner u_occal_partner (.*);

    always #2 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; data and error taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] cfg(input int st, cp, hd, t1, t2, m2);
        return 32'((st << occal_pkg::STARTUP_LSB) | (cp << occal_pkg::CALPER_LSB)
            | (hd << occal_pkg::HSDIV_LSB) | (t1 << occal_pkg::TO1_LSB)
            | (t2 << occal_pkg::TO2_LSB) | (m2 << occal_pkg::MODE2_BIT));
    endfunction

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, occal_pkg::CFG_OFS, 0);
        chk("cfg", occal_pkg::CFG_RESET, q);
        apb(0, occal_pkg::STATUS_OFS, 0);
        chk("status", 32'h0000_0001, q);
        apb(0, 8'h1C, 0);
        chk("unmapped", 32'h0000_0001, {q[30:0], e});
        // continuous and off settings, mode 2 gate
        apb(1, occal_pkg::CFG_OFS, cfg(1, 0, 0, 0, 0, 1));
        repeat (2) @(posedge pclk);
        chk("osc on", 32'h0000_0003, {hs_osc_enable, mode2_hs_enable});
        apb(1, occal_pkg::CFG_OFS, cfg(0, 0, 0, 7, 7, 0));
        repeat (3) @(posedge pclk);
        chk("osc off", 0, hs_osc_enable);
        // lf outputs run with the oscillator off
        x = 0;
        n = 0;
        repeat (1280) begin
            f0 = fire_input_pin_o;
            s0 = start_enable_pin_o;
            @(posedge pclk);
            if (fire_input_pin_o === 1'b1 && f0 === 1'b0) x++;
            if (start_enable_pin_o === 1'b1 && s0 === 1'b0) n++;
        end
        chk("pin oe", 32'h0000_0003, {fire_input_pin_oe, start_enable_pin_oe});
        chk("lf rises", 16, x);
        chk("lf8 rises", 2, n);
        // every measurement opcode and settle code above 1; measurement irq masked
        apb(1, occal_pkg::IRQ_EN_OFS, 32'h0000_0001);
        for (int s = 2; s < 8; s++) begin
            lat <= 8'(s == 2 ? 2 : s * 8);
            apb(1, occal_pkg::CFG_OFS, cfg(s, 0, 0, 0, 0, 0));
            apb(1, occal_pkg::CMD_OFS, 32'(s % 4 + 1));
            x = s == 2 ? 20 : s == 3 ? 40 : s == 4 ? 60 : 80;
            for (n = 0; n < 300 && meas_start !== 1'b1; n++) @(posedge pclk);
            chk("settle", 1, n >= x && n <= x + 3);
            chk("osc at start", 1, hs_osc_enable);
            repeat (s * 8 + 4) @(posedge pclk);
            chk("osc after", 0, hs_osc_enable);
        end
        chk("irq masked", 0, irq);
        apb(0, occal_pkg::IRQ_STS_OFS, 0);
        chk("irq status", 32'h0000_0002, q);
        apb(1, occal_pkg::IRQ_CLR_OFS, 32'h0000_0002);
        // calibration, every period count and divider
        for (int c = 0; c < 4; c++) begin
            apb(1, occal_pkg::CFG_OFS, cfg(0, c, c, 0, 0, 0));
            apb(1, occal_pkg::CMD_OFS, 32'(occal_pkg::OP_CAL));
            for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge pclk);
            chk("cal irq", 1, irq);
            apb(0, occal_pkg::RESULT_OFS, 0);
            x = (2 << c) * 20 / (c == 0 ? 1 : c == 1 ? 2 : 4);
            n_tests++;
            if ($isunknown(q) || q[15:0] !== 16'h0 || q[31:16] + 1 < x || q[31:16] > x + 1) begin
                n_mismatch++;
                $display("FAIL result expected %h seen %h", x, q);
            end
            apb(1, occal_pkg::IRQ_CLR_OFS, 32'h0000_0001);
            @(posedge pclk);
            chk("irq clear", 0, irq);
        end
        start_input_enabled <= 1'b0;
        apb(1, occal_pkg::CMD_OFS, 32'h0000_0005);
        repeat (2) apb(0, occal_pkg::STATUS_OFS, 0);
        chk("cal err", 32'h0000_0078, q);
        close_out();
    end
endmodule
`default_nettype wire
